/* File: rseq_params.svh */
// Purpose: constants for the rail enable sequencer
// Assumes: 50 MHz clock
// Notes: offsets, field positions, reset values, timing counts
`ifndef RSEQ_PARAMS_SVH
`define RSEQ_PARAMS_SVH

`define RSEQ_ADDR_ENABLE 8'h05
`define RSEQ_BIT_BOOST 0
`define RSEQ_BIT_NEG 1
`define RSEQ_BIT_POS 2
`define RSEQ_BIT_HIZ 6
`define RSEQ_ENABLE_RESET 8'h07
`define RSEQ_CLK_HZ 50000000
`define RSEQ_NEG_DELAY_US 2000
`define RSEQ_NEG_DELAY_CYC ((`RSEQ_CLK_HZ / 1000000) * `RSEQ_NEG_DELAY_US)

`endif

/* File: rseq_pkg.sv */
// Purpose: types for the rail enable sequencer
// Assumes: nothing
// Notes: register write carrier and negative rail state
package rseq_pkg;
    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] data;
    } rseq_wr_t;

    typedef enum logic [2:0] {
        RSEQ_NEG_OFF = 3'b001,
        RSEQ_NEG_WAIT = 3'b010,
        RSEQ_NEG_ON = 3'b100
    } rseq_neg_state_t;
endpackage

/* File: rseq_rail_enable_sequencer.sv */
// Purpose: rail enable sequencing for a boost-fed positive and negative bias supply
// Assumes: the serial front end presents each written byte and a stop pulse on clk
// Notes:
// Notes on behaviour
// - control bit 1 enables negative rail, bit 2 enables positive rail
// - written data takes effect at stop; both bits together start positive rail first, negative after the delay
// - writing 0x07 starts positive rail at stop, negative after 2ms
// - negative rail waits 2ms after its enable pin rises
// - pins act only while matching bits are one; defaults let pins sequence alone
// - both pins high together: positive first, negative 2ms later
// - both pins falling together shut both rails at once
// - bit 6 set removes positive rail pull-down while rail is off
// - boost, negative and positive enable bits reset to one
// - boost runs while either pin high and its bit set
// - positive rail starts only with pin high and boost soft-start done
`timescale 1ns/10ps
`include "rseq_params.svh"

module rseq_rail_enable_sequencer #(
    parameter int NEG_DELAY_CYC = `RSEQ_NEG_DELAY_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic positive_rail_enable_pin,
    input wire logic negative_rail_enable_pin,
    input wire rseq_pkg::rseq_wr_t reg_wr,
    input wire logic reg_stop,
    input wire logic [7:0] reg_rd_addr,
    output logic [7:0] reg_rd_data,
    input wire logic boost_rail_ss_done,
    output logic boost_rail_en,
    output logic positive_rail_en,
    output logic negative_rail_en,
    output logic positive_rail_pulldown_en
);
    localparam int CW = $clog2(NEG_DELAY_CYC + 1);

    // ====================================================
    // pin synchronisers
    logic [1:0] pos_sync_q;
    logic [1:0] neg_sync_q;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pos_sync_q <= 2'h0;
            neg_sync_q <= 2'h0;
        end else begin
            pos_sync_q <= {pos_sync_q[0], positive_rail_enable_pin};
            neg_sync_q <= {neg_sync_q[0], negative_rail_enable_pin};
        end
    end
    wire logic pos_pin = pos_sync_q[1];
    wire logic neg_pin = neg_sync_q[1];

    // ====================================================
    // enable register: staged byte, committed at stop
    logic [7:0] ctrl_q;
    logic [7:0] stage_q;
    logic stage_vld_q;
    // one decoder shared by staging, read-back and the checks
    function automatic logic hit_enable(input logic [7:0] addr);
        return addr == `RSEQ_ADDR_ENABLE;
    endfunction
    always_ff @(posedge clk) begin
        if (!rstn) begin
            stage_vld_q <= 1'b0;
            stage_q <= 8'h00;
        end else if (reg_stop) begin
            stage_vld_q <= 1'b0;
        end else if (reg_wr.valid && hit_enable(reg_wr.addr)) begin
            stage_vld_q <= 1'b1;
            stage_q <= reg_wr.data;
        end
    end
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_q <= `RSEQ_ENABLE_RESET;
        end else if (reg_stop && stage_vld_q) begin
            ctrl_q <= stage_q;
        end
    end
    always_ff @(posedge clk) begin
        if (!rstn) begin
            reg_rd_data <= 8'h00;
        end else if (hit_enable(reg_rd_addr)) begin
            reg_rd_data <= ctrl_q;
        end else begin
            reg_rd_data <= 8'h00;
        end
    end

    // ====================================================
    // rail enable conditions
    logic boost_cond;
    logic pos_cond;
    logic neg_cond;
    always_comb begin
        boost_cond = (pos_pin | neg_pin) & ctrl_q[`RSEQ_BIT_BOOST];
        // pins gate with bits, so default bits let pins act alone
        pos_cond = boost_cond & pos_pin & ctrl_q[`RSEQ_BIT_POS];
        neg_cond = boost_cond & neg_pin & ctrl_q[`RSEQ_BIT_NEG];
    end

    // ====================================================
    // negative rail delay: counts from later of enable and boost done
    rseq_pkg::rseq_neg_state_t neg_st_q;
    logic [CW-1:0] cnt_q;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            neg_st_q <= rseq_pkg::RSEQ_NEG_OFF;
            cnt_q <= '0;
        end else if (!neg_cond) begin
            neg_st_q <= rseq_pkg::RSEQ_NEG_OFF;
            cnt_q <= '0;
        end else begin
            case (neg_st_q)
                rseq_pkg::RSEQ_NEG_OFF: begin
                    cnt_q <= '0;
                    if (boost_rail_ss_done) begin
                        neg_st_q <= rseq_pkg::RSEQ_NEG_WAIT;
                    end
                end
                rseq_pkg::RSEQ_NEG_WAIT: begin
                    if (cnt_q == CW'(NEG_DELAY_CYC - 1)) begin
                        neg_st_q <= rseq_pkg::RSEQ_NEG_ON;
                    end else begin
                        cnt_q <= cnt_q + CW'(1);
                    end
                end
                rseq_pkg::RSEQ_NEG_ON: begin
                    neg_st_q <= rseq_pkg::RSEQ_NEG_ON;
                end
                default: begin
                    neg_st_q <= rseq_pkg::RSEQ_NEG_OFF;
                end
            endcase
        end
    end

    // ====================================================
    // registered outputs to the power stages
    always_ff @(posedge clk) begin
        if (!rstn) begin
            boost_rail_en <= 1'b0;
            positive_rail_en <= 1'b0;
            negative_rail_en <= 1'b0;
            positive_rail_pulldown_en <= 1'b1;
        end else begin
            boost_rail_en <= boost_cond;
            positive_rail_en <= pos_cond & boost_rail_ss_done;
            // both rails drop on the same edge, no delay on shutdown
            negative_rail_en <= neg_cond & (neg_st_q == rseq_pkg::RSEQ_NEG_ON);
            positive_rail_pulldown_en <= ~(pos_cond & boost_rail_ss_done)
                & ~ctrl_q[`RSEQ_BIT_HIZ];
        end
    end

    // ====================================================
    // checks
    a_stop_commit: assert property (@(posedge clk) disable iff (!rstn)
        reg_stop && stage_vld_q |=> ctrl_q == $past(stage_q))
        else $error("enable byte not committed at stop");
    a_reset_bits: assert property (@(posedge clk)
        !rstn |=> ctrl_q == `RSEQ_ENABLE_RESET)
        else $error("enable bits not reset to one");
    a_neg_early: assert property (@(posedge clk) disable iff (!rstn)
        $rose(neg_cond) |-> !negative_rail_en [*3])
        else $error("negative rail rose without delay");
    a_neg_clear: assert property (@(posedge clk) disable iff (!rstn)
        !neg_cond |=> cnt_q == '0 && neg_st_q == rseq_pkg::RSEQ_NEG_OFF)
        else $error("delay counter not cleared");
    a_both_off: assert property (@(posedge clk) disable iff (!rstn)
        !boost_cond |=> !positive_rail_en && !negative_rail_en)
        else $error("rails not shut together");
    a_boost_en: assert property (@(posedge clk) disable iff (!rstn)
        boost_cond |=> boost_rail_en)
        else $error("boost not enabled");
    a_pos_gate: assert property (@(posedge clk) disable iff (!rstn)
        positive_rail_en |-> $past(pos_pin) && $past(boost_rail_ss_done))
        else $error("positive rail on without cause");
    a_hiz_mode: assert property (@(posedge clk) disable iff (!rstn)
        ctrl_q[`RSEQ_BIT_HIZ] |=> !positive_rail_pulldown_en)
        else $error("pull-down active in hi-z mode");
    a_neg_gate: assert property (@(posedge clk) disable iff (!rstn)
        negative_rail_en |-> $past(neg_pin) && $past(ctrl_q[`RSEQ_BIT_NEG]))
        else $error("negative rail on without pin and bit");

    // ====================================================
    // check helpers
    // age of the negative enable, kept apart from the design counter
    // so a counter that fails to clear is still caught
    logic [CW-1:0] neg_age_q;
    always_ff @(posedge clk) begin
        if (!rstn || !neg_cond) begin
            neg_age_q <= '0;
        end else if (neg_age_q != CW'(NEG_DELAY_CYC)) begin
            neg_age_q <= neg_age_q + CW'(1);
        end
    end
    sequence s_wr_enable;
        reg_wr.valid && hit_enable(reg_wr.addr) && !reg_stop;
    endsequence
    sequence s_wr_commit;
        s_wr_enable ##1 reg_stop;
    endsequence
    sequence s_both_up;
        $rose(pos_cond) && $rose(neg_cond) && boost_rail_ss_done;
    endsequence
    a_neg_age: assert property (@(posedge clk) disable iff (!rstn)
        negative_rail_en |-> neg_age_q == CW'(NEG_DELAY_CYC))
        else $error("negative rail on before full delay");
    a_wr_commit: assert property (@(posedge clk) disable iff (!rstn)
        s_wr_commit |=> ctrl_q == $past(reg_wr.data, 2))
        else $error("written byte not applied at stop");
    a_pos_first: assert property (@(posedge clk) disable iff (!rstn)
        s_both_up |=> positive_rail_en && !negative_rail_en)
        else $error("positive rail not first");
    a_boost_off: assert property (@(posedge clk) disable iff (!rstn)
        !boost_cond |=> !boost_rail_en)
        else $error("boost left on");
    a_pulldown_on: assert property (@(posedge clk) disable iff (!rstn)
        !ctrl_q[`RSEQ_BIT_HIZ] |=> positive_rail_pulldown_en == !positive_rail_en)
        else $error("pull-down state wrong");
endmodule // rseq_rail_enable_sequencer

/* File: rseq_host_model.sv */
// Purpose: host side model, one enable byte then a stop
// Assumes: go is a one-cycle request from the bench
// Notes: idle fields toggle so stale bytes never look valid
`timescale 1ns/10ps
// ==========
// host writer
module rseq_host_model (
    input wire logic clk,
    input wire logic go,
    input wire logic [15:0] req,
    output rseq_pkg::rseq_wr_t reg_wr,
    output logic reg_stop
);
    logic pend_q;
    always @(posedge clk) begin
        pend_q <= go;
        reg_stop <= pend_q;
        reg_wr.valid <= go;
        reg_wr.addr <= go ? req[15:8] : ~reg_wr.addr;
        reg_wr.data <= go ? req[7:0] : ~reg_wr.data;
    end
endmodule // rseq_host_model

/* File: testbench.sv */
// Purpose: self-checking bench for the rail enable sequencer
// Assumes: delay shortened to 20 cycles
// Notes: pins and boost soft-start driven by the bench
`timescale 1ns/10ps
`define CHK(n,e,s) \
    begin \
        #1; \
        tests_run++; \
        if ((s) !== (e)) begin \
            num_errors++; \
            $display("mismatch %s exp %h got %h", n, e, s); \
        end \
    end
// ==========
// bench
module testbench;
    logic clk, rstn, pp, np, ss, go, boost, pos, neg, pd, stop;
    logic [15:0] req;
    logic [7:0] ra, rdata, d;
    rseq_pkg::rseq_wr_t wrb;
    int num_errors = 0, tests_run = 0, cycles = 0, seed = 47029;
    rseq_host_model host (.clk(clk), .go(go), .req(req), .reg_wr(wrb), .reg_stop(stop));
    rseq_rail_enable_sequencer #(.NEG_DELAY_CYC(20)) dut (.clk(clk), .rstn(rstn),
        .positive_rail_enable_pin(pp), .negative_rail_enable_pin(np), .reg_wr(wrb),
        .reg_stop(stop), .reg_rd_addr(ra), .reg_rd_data(rdata),
        .boost_rail_ss_done(ss), .boost_rail_en(boost), .positive_rail_en(pos),
        .negative_rail_en(neg), .positive_rail_pulldown_en(pd));
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task wr(input logic [15:0] r);
        @(posedge clk);
        go <= 1'b1;
        req <= r;
        @(posedge clk);
        go <= 1'b0;
        cyc(3);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        ra <= a;
        cyc(2);
        `CHK("read", e, rdata)
    endtask
    // boost, pos, neg, pulldown
    function logic [3:0] exp_out(input logic [7:0] v, input logic p, input logic n);
        logic b;
        b = v[0] & (p | n);
        return {b, b & v[2] & p, b & v[1] & n, ~(b & v[2] & p) & ~v[6]};
    endfunction
    task stop_test;
        $display("counts: %0d checks, %0d mismatches", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // sequence is about 510 cycles; ceiling leaves ample margin
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            num_errors++;
            stop_test();
        end
    end
    initial begin
        rstn = 0;
        pp = 0;
        np = 0;
        ss = 1;
        go = 0;
        req = '0;
        ra = '0;
        cyc(8);
        rstn <= 1'b1;
        rd(8'h05, 8'h07);
        `CHK("idle", 4'b0001, {boost, pos, neg, pd})
        cyc(1);
        pp <= 1'b1;
        np <= 1'b1;
        cyc(6);
        `CHK("pos first", 2'b10, {pos, neg})
        cyc(10);
        `CHK("neg held", 1'b0, neg)
        cyc(15);
        `CHK("neg late", 1'b1, neg)
        cyc(1);
        pp <= 1'b0;
        np <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            cyc(1);
            `CHK("fall", (i < 2) ? 2'b11 : 2'b00, {pos, neg})
        end
        `CHK("down", 4'b0001, {boost, pos, neg, pd})
        $display("test pins done");
        cyc(1);
        ss <= 1'b0;
        pp <= 1'b1;
        cyc(10);
        `CHK("ss gate", 2'b10, {boost, pos})
        cyc(1);
        ss <= 1'b1;
        np <= 1'b1;
        cyc(10);
        np <= 1'b0;
        cyc(3);
        np <= 1'b1;
        cyc(15);
        `CHK("restart", 2'b10, {pos, neg})
        cyc(10);
        `CHK("restart end", 1'b1, neg)
        wr(16'h0500);
        cyc(30);
        `CHK("bits off", 4'b0001, {boost, pos, neg, pd})
        wr(16'h0507);
        cyc(2);
        `CHK("commit", 2'b10, {pos, neg})
        cyc(25);
        `CHK("commit neg", 1'b1, neg)
        wr(16'h0600);
        rd(8'h05, 8'h07);
        rd(8'h06, 8'h00);
        cyc(1);
        pp <= 1'b0;
        np <= 1'b0;
        wr(16'h0540);
        cyc(5);
        `CHK("hiz", 1'b0, pd)
        $display("test register done");
        repeat (8) begin
            d = 8'($random(seed));
            cyc(1);
            pp <= d[4];
            np <= d[5];
            wr({8'h05, d});
            cyc(30);
            `CHK("rails", exp_out(d, d[4], d[5]), {boost, pos, neg, pd})
            rd(8'h05, d);
        end
        $display("test random done");
        cyc(1);
        rstn <= 1'b0;
        cyc(3);
        rstn <= 1'b1;
        rd(8'h05, 8'h07);
        $display("test reset done");
        stop_test();
    end
endmodule // testbench
